// ===== design/fesc_pkg.sv
// How it works
// - nibbles A..F encode to 10110,10111,11010,11011,11100,11101; decoder inverts
// - nibbles 0..9 encode to 11110..10011; only sixteen patterns carry data
// - 11000 after idle decodes as 0101 (first delimiter half), else receive error
// - 10001 directly after first delimiter half decodes as 0101, else error
// - 01101 is first end symbol; carrier drops if second follows, else error
// - 00111 ends carrier only right after first end symbol, else error
// - ten invalid groups never sent; receiver flags error on them during valid
// - scrambler seed is derived from the port address, unique per port
// - five-bit groups are serialised bit by bit, then scrambled per bit
// - serial bits become an NRZI stream at the symbol bit rate
// - MLT-3 steps to next of three levels on a one, holds on a zero
// - receive front end passes one 6-bit sample per bit slot
// - a phase mux steered by the timing unit picks the sampling phase
package fesc_pkg;
    localparam logic [4:0] CG_IDLE = 5'h1F;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0D;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_H = 5'h04;
    localparam logic [3:0] NIB_SSD = 4'h5;
    localparam logic [3:0] NIB_BAD_SSD = 4'hE;
    localparam logic [10:0] SCR_SEED_BASE = 11'h5A3;
    localparam int SYM_BITS = 5;
    localparam int PHASES = 4;

    typedef enum logic [1:0] {
        MLT_ZERO = 2'b00,
        MLT_POS = 2'b01,
        MLT_NEG = 2'b10
    } fesc_mlt_t;

    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] d;
    } fesc_mii_tx_t;

    typedef struct packed {
        logic crs;
        logic dv;
        logic er;
        logic [3:0] d;
    } fesc_mii_rx_t;

    // 4b -> 5b data group
    function automatic logic [4:0] enc5(input logic [3:0] n);
        logic [4:0] c;
        c = 5'h1E;
        case (n)
            4'h0: c = 5'h1E;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0A;
            4'h5: c = 5'h0B;
            4'h6: c = 5'h0E;
            4'h7: c = 5'h0F;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'hA: c = 5'h16;
            4'hB: c = 5'h17;
            4'hC: c = 5'h1A;
            4'hD: c = 5'h1B;
            4'hE: c = 5'h1C;
            default: c = 5'h1D;
        endcase
        return c;
    endfunction

    // 5b -> {is_data, nibble}
    function automatic logic [4:0] dec5(input logic [4:0] c);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (enc5(4'(i)) == c) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction
endpackage

// ===== design/fesc_shift.sv
`timescale 1ns/100ps
// parallel-in serial-out for one code group, msb first
module fesc_shift #(
    parameter int W = 5
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic load_in,
    input wire logic [W-1:0] par_in,
    output logic ser_out
);
    logic [W-1:0] sh_q;
    logic [W-1:0] sh_d;

    always_comb begin
        sh_d = sh_q;
        if (load_in) begin
            sh_d = par_in;
        end else begin
            sh_d = {sh_q[W-2:0], 1'b0};
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sh_q <= '1;
        end else if (ce_in) begin
            sh_q <= sh_d;
        end
    end

    assign ser_out = sh_q[W-1];
endmodule // fesc_shift

// ===== design/fesc_top.sv
`timescale 1ns/100ps
// clk_in is the bit-rate clock in this model (one line bit per enabled cycle)
module fesc_top #(
    parameter int PHASES = fesc_pkg::PHASES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic [4:0] phy_addr_in,
    input wire fesc_pkg::fesc_mii_tx_t mii_tx_in,
    output logic mii_tx_take_out,
    output fesc_pkg::fesc_mii_rx_t mii_rx_out,
    output logic rx_nib_valid_out,
    output fesc_pkg::fesc_mlt_t mlt_out,
    input wire logic [5:0] adc_sample_in,
    output logic [5:0] dsp_sample_out,
    input wire logic [PHASES-1:0] rx_phase_in,
    input wire logic [$clog2(PHASES)-1:0] phase_sel_in,
    output logic rx_rclk_out,
    input wire logic [4:0] rx_group_in,
    input wire logic rx_group_valid_in
);
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_J = 3'b001,
        TX_K = 3'b010,
        TX_DATA = 3'b011,
        TX_T = 3'b100,
        TX_R = 3'b101
    } fesc_tx_t;

    // ---------------- transmit ----------------
    fesc_tx_t st_q, st_d;
    logic [2:0] bit_q, bit_d;
    logic [4:0] grp_q, grp_d;
    logic [10:0] scr_q, scr_d;
    logic nrzi_q, nrzi_d;
    fesc_pkg::fesc_mlt_t mlt_q, mlt_d;
    logic last_pol_q, last_pol_d;
    logic load;
    logic ser;

    assign load = (bit_q == 3'(fesc_pkg::SYM_BITS - 1));
    // a nibble is used up at every group boundary of a frame; J and K
    // stand in for the first two, so no nibble goes out twice
    assign mii_tx_take_out = ce_in && load && mii_tx_in.en
        && st_q != TX_T && st_q != TX_R;

    always_comb begin
        st_d = st_q;
        grp_d = grp_q;
        bit_d = load ? 3'h0 : bit_q + 3'h1;
        if (load) begin
            case (st_q)
                TX_IDLE: begin
                    grp_d = fesc_pkg::CG_IDLE;
                    if (mii_tx_in.en) begin
                        st_d = TX_J;
                        grp_d = fesc_pkg::CG_J;
                    end
                end
                TX_J: begin
                    st_d = TX_K;
                    grp_d = fesc_pkg::CG_K;
                end
                TX_K, TX_DATA: begin
                    if (mii_tx_in.en) begin
                        st_d = TX_DATA;
                        grp_d = mii_tx_in.er ? fesc_pkg::CG_H
                              : fesc_pkg::enc5(mii_tx_in.d);
                    end else begin
                        st_d = TX_T;
                        grp_d = fesc_pkg::CG_T;
                    end
                end
                TX_T: begin
                    st_d = TX_R;
                    grp_d = fesc_pkg::CG_R;
                end
                default: begin
                    st_d = TX_IDLE;
                    grp_d = fesc_pkg::CG_IDLE;
                end
            endcase
        end
    end

    fesc_shift #(.W(fesc_pkg::SYM_BITS)) u_piso (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .load_in(load),
        .par_in(grp_d),
        .ser_out(ser)
    );

    // address seeding on first enabled cycle after reset; the low six bits
    // always come out as 100010, so the key can never start all zero
    logic seeded_q;
    logic [10:0] scr_seed;
    logic [10:0] scr_use;
    assign scr_seed = fesc_pkg::SCR_SEED_BASE ^ {phy_addr_in, 6'h01};
    assign scr_use = seeded_q ? scr_q : scr_seed;

    // x^11 + x^9 + 1 stream scrambler, then nrzi and mlt-3
    always_comb begin
        scr_d = {scr_use[9:0], scr_use[10] ^ scr_use[8]};
        nrzi_d = nrzi_q ^ (ser ^ scr_use[10]);
        mlt_d = mlt_q;
        last_pol_d = last_pol_q;
        if (nrzi_d != nrzi_q) begin
            case (mlt_q)
                fesc_pkg::MLT_ZERO: begin
                    mlt_d = last_pol_q ? fesc_pkg::MLT_NEG : fesc_pkg::MLT_POS;
                    last_pol_d = ~last_pol_q;
                end
                default: mlt_d = fesc_pkg::MLT_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_q <= TX_IDLE;
            bit_q <= 3'h0;
            grp_q <= fesc_pkg::CG_IDLE;
            // seed mixes in the address after release; never all zero
            scr_q <= fesc_pkg::SCR_SEED_BASE;
            nrzi_q <= 1'b0;
            mlt_q <= fesc_pkg::MLT_ZERO;
            last_pol_q <= 1'b0;
        end else if (ce_in) begin
            st_q <= st_d;
            bit_q <= bit_d;
            grp_q <= grp_d;
            scr_q <= scr_d;
            nrzi_q <= nrzi_d;
            mlt_q <= mlt_d;
            last_pol_q <= last_pol_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            seeded_q <= 1'b0;
        end else if (ce_in) begin
            seeded_q <= 1'b1;
        end
    end
    assign mlt_out = mlt_q;

    // ---------------- receive front end ----------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            dsp_sample_out <= 6'h00;
        end else if (ce_in) begin
            dsp_sample_out <= adc_sample_in;
        end
    end
    assign rx_rclk_out = rx_phase_in[phase_sel_in];

    // ---------------- 5b/4b decode ----------------
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_GOT_J = 2'b01,
        RX_FRAME = 2'b10,
        RX_GOT_T = 2'b11
    } fesc_rxs_t;
    fesc_rxs_t rs_q, rs_d;
    fesc_pkg::fesc_mii_rx_t rx_q, rx_d;
    logic rv_q, rv_d;
    logic [4:0] dd;

    always_comb begin
        rs_d = rs_q;
        rx_d = rx_q;
        rv_d = 1'b0;
        dd = fesc_pkg::dec5(rx_group_in);
        if (rx_group_valid_in) begin
            rv_d = 1'b1;
            rx_d.er = 1'b0;
            case (rs_q)
                RX_IDLE: begin
                    rx_d.dv = 1'b0;
                    rx_d.crs = 1'b0;
                    if (rx_group_in == fesc_pkg::CG_J) begin
                        rs_d = RX_GOT_J;
                        rx_d.crs = 1'b1;
                        rx_d.d = fesc_pkg::NIB_SSD;
                    end else if (rx_group_in != fesc_pkg::CG_IDLE) begin
                        rx_d.er = 1'b1;
                    end
                end
                RX_GOT_J: begin
                    if (rx_group_in == fesc_pkg::CG_K) begin
                        rs_d = RX_FRAME;
                        rx_d.dv = 1'b1;
                        rx_d.d = fesc_pkg::NIB_SSD;
                    end else begin
                        rs_d = RX_IDLE;
                        rx_d.er = 1'b1;
                        rx_d.crs = 1'b0;
                        rx_d.d = fesc_pkg::NIB_BAD_SSD;
                    end
                end
                RX_FRAME: begin
                    if (rx_group_in == fesc_pkg::CG_T) begin
                        rs_d = RX_GOT_T;
                    end else if (dd[4]) begin
                        rx_d.d = dd[3:0];
                    end else begin
                        // I, J, K, R, H and the ten invalid groups
                        rx_d.er = 1'b1;
                    end
                end
                default: begin
                    if (rx_group_in == fesc_pkg::CG_R) begin
                        rs_d = RX_IDLE;
                        rx_d.crs = 1'b0;
                        rx_d.dv = 1'b0;
                    end else begin
                        rs_d = RX_FRAME;
                        rx_d.er = 1'b1;
                        // data after a lone T is still passed on, flagged
                        if (dd[4]) begin
                            rx_d.d = dd[3:0];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rs_q <= RX_IDLE;
            rx_q <= '0;
            rv_q <= 1'b0;
        end else if (ce_in) begin
            rs_q <= rs_d;
            rx_q <= rx_d;
            rv_q <= rv_d;
        end
    end
    assign mii_rx_out = rx_q;
    assign rx_nib_valid_out = rv_q;
endmodule // fesc_top

// ===== sim/fesc_chk_assertions.sv
`timescale 1ns/100ps
module fesc_chk #(
    parameter int PHASES = 4
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic mii_tx_take_out,
    input wire fesc_pkg::fesc_mii_rx_t mii_rx_out,
    input wire fesc_pkg::fesc_mlt_t mlt_out,
    input wire logic [5:0] adc_sample_in,
    input wire logic [5:0] dsp_sample_out,
    input wire logic [PHASES-1:0] rx_phase_in,
    input wire logic [$clog2(PHASES)-1:0] phase_sel_in,
    input wire logic rx_rclk_out,
    input wire logic [4:0] rx_group_in,
    input wire logic rx_group_valid_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    logic v;
    assign v = rx_group_valid_in && ce_in;
    a_sample_delay: assert property (
        ce_in |=> dsp_sample_out == $past(adc_sample_in))
        else $error("sample not passed on");
    a_sample_hold: assert property (
        !ce_in |=> $stable(dsp_sample_out))
        else $error("sample moved while frozen");
    a_phase_pick: assert property (
        rx_rclk_out == rx_phase_in[phase_sel_in])
        else $error("wrong clock phase");
    // from either outer level the only step is back to zero
    a_mlt_step: assert property (
        ($past(mlt_out) != fesc_pkg::MLT_ZERO && mlt_out != $past(mlt_out))
        |-> mlt_out == fesc_pkg::MLT_ZERO)
        else $error("illegal line level step");
    a_take_spacing: assert property (
        mii_tx_take_out |=> !mii_tx_take_out [*4])
        else $error("nibbles taken too close");
    a_data_decode: assert property (
        v && mii_rx_out.dv && rx_group_in == 5'h16
        |=> mii_rx_out.d == 4'hA)
        else $error("data group misdecoded");
    a_invalid_err: assert property (
        v && mii_rx_out.dv && rx_group_in inside {5'h00, 5'h01, 5'h02,
        5'h03, 5'h05, 5'h08, 5'h0C, 5'h10, 5'h06, 5'h19}
        |=> mii_rx_out.er)
        else $error("invalid group not flagged");
    a_stream_end: assert property (
        (v && rx_group_in == fesc_pkg::CG_T && mii_rx_out.dv) ##1
        (v && rx_group_in == fesc_pkg::CG_R)
        |=> !mii_rx_out.crs && !mii_rx_out.dv)
        else $error("carrier kept after end pair");
endmodule // fesc_chk

bind fesc_top fesc_chk #(.PHASES(PHASES)) u_chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .mii_tx_take_out(mii_tx_take_out), .mii_rx_out(mii_rx_out),
    .mlt_out(mlt_out), .adc_sample_in(adc_sample_in),
    .dsp_sample_out(dsp_sample_out), .rx_phase_in(rx_phase_in),
    .phase_sel_in(phase_sel_in), .rx_rclk_out(rx_rclk_out),
    .rx_group_in(rx_group_in), .rx_group_valid_in(rx_group_valid_in));

// ===== sim/fesc_mac_model.sv
`timescale 1ns/100ps
// mac side: swaps the nibble only after the design took it
module fesc_mac_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [7:0] len_in,
    input wire logic err_in,
    input wire logic take_in,
    output fesc_pkg::fesc_mii_tx_t tx_out,
    output logic busy_out
);
    integer seed = 99;
    int left = 0;
    logic took = 1'b0;
    initial tx_out = '0;
    assign busy_out = left != 0;
    always @(posedge clk_in) took <= take_in;
    always @(negedge clk_in) begin
        if (go_in && left == 0) begin
            left = len_in;
            tx_out.en <= 1'b1;
            tx_out.d <= 4'($random(seed));
        end else if (took && left != 0) begin
            left = left - 1;
            tx_out.en <= left != 0;
            tx_out.er <= err_in && left == 2;
            // released data is flipped so stale values never match
            tx_out.d <= left != 0 ? 4'($random(seed)) : ~tx_out.d;
        end
    end
endmodule // fesc_mac_model

// ===== sim/test_fesc_top.sv
`timescale 1ns/100ps
module test_fesc_top;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [4:0] phy_addr_in = 5'h01;
    fesc_pkg::fesc_mii_tx_t mii_tx;
    fesc_pkg::fesc_mii_rx_t mii_rx;
    fesc_pkg::fesc_mlt_t mlt;
    logic take, nv, rclk, go = 1'b0, busy, diff;
    logic [5:0] adc = 6'h00, dsp;
    logic [3:0] ph = 4'h0, n;
    logic [1:0] psel = 2'h0;
    logic [4:0] grp = 5'h1F;
    logic gv = 1'b0;
    logic [1:0] mlt_a [60];
    integer seed = 99;
    int miscompares = 0, num_checks = 0, e;
    int nj = 0, nh = 0, nbad = 0, ntk = 0, lk = -1, nj0, nh0, tk0;
    logic [10:0] zh = '0;
    logic [4:0] lg = '0;
    logic [1:0] lm = 2'h0;
    logic zb, sb;
    logic [4:0] cg [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
        5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic [4:0] bad [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h08,
        5'h0C, 5'h10, 5'h06, 5'h19};

    fesc_top uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
        .phy_addr_in(phy_addr_in), .mii_tx_in(mii_tx),
        .mii_tx_take_out(take), .mii_rx_out(mii_rx),
        .rx_nib_valid_out(nv), .mlt_out(mlt), .adc_sample_in(adc),
        .dsp_sample_out(dsp), .rx_phase_in(ph), .phase_sel_in(psel),
        .rx_rclk_out(rclk), .rx_group_in(grp), .rx_group_valid_in(gv));
    fesc_mac_model u_mac (.clk_in(clk_in), .go_in(go), .len_in(8'(e)),
        .err_in(e[0]), .take_in(take), .tx_out(mii_tx), .busy_out(busy));

    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (take) begin
            ntk++;
        end
    end
    // line monitor: key learned from the idle bits after reset, so it
    // does not lean on how the seed is formed
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            lk = -1;
        end else if (ce_in) begin
            if (lk >= 0) begin
                zb = (lk < 11) ? (mlt == lm) : (zh[10] ^ zh[8]);
                sb = (mlt != lm) ^ zb;
                zh = {zh[9:0], zb};
                lg = {lg[3:0], sb};
                if (lk % 5 == 4) begin
                    if (lg == fesc_pkg::CG_J) begin
                        nj++;
                    end
                    if (lg == fesc_pkg::CG_H) begin
                        nh++;
                    end
                    for (int i = 0; i < 10; i++) begin
                        if (lg == bad[i]) begin
                            nbad++;
                        end
                    end
                end
            end
            lm = mlt;
            lk++;
        end
    end
    always @(negedge clk_in) begin
        adc <= 6'($random(seed));
        ph <= 4'($random(seed));
        psel <= 2'($random(seed));
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // groups go back to back; result is settled one negedge later
    task automatic rx(input logic [4:0] g);
        grp = g;
        gv = 1'b1;
        @(negedge clk_in);
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        miscompares++;
        report_and_stop;
    end

    initial begin
        repeat (12) @(negedge clk_in);
        sys_rst_in = 1'b0;
        for (int f = 0; f < 40; f++) begin
            e = f % 4;
            if (e == 3) begin
                rx(5'h1F); rx(5'h18); rx(cg[f % 16]);
                chk(8'(mii_rx[6:0]), 8'h1E);
            end
            rx(5'h1F); rx(5'h1F);
            rx(5'h18); chk(8'(mii_rx[5:0]), 8'h05);
            rx(5'h11); chk(8'(mii_rx[5:0]), 8'h25);
            for (int i = 0; i < (f == 0 ? 16 : 4); i++) begin
                n = f == 0 ? 4'(i) : 4'($random(seed));
                rx(cg[n]); chk(8'(mii_rx[5:0]), {4'h2, n});
            end
            if (e == 1) begin
                rx(bad[f / 4]); chk(8'(mii_rx.er), 8'h01);
            end
            if (e == 2) begin
                rx(5'h18); chk(8'(mii_rx.er), 8'h01);
            end
            if (e == 3) begin
                rx(5'h0D); rx(cg[7]); chk(8'(mii_rx.er), 8'h01);
                rx(5'h07); chk(8'(mii_rx.er), 8'h01);
            end
            rx(5'h0D); rx(5'h07); chk(8'(mii_rx[6:5]), 8'h00);
        end
        chk(8'(nv), 8'h01);
        gv = 1'b0;
        @(negedge clk_in);
        chk(8'(nv), 8'h00);
        // idle line after reset must differ between two port addresses
        for (int a = 0; a < 2; a++) begin
            sys_rst_in = 1'b1;
            phy_addr_in = 5'(a + 1);
            repeat (2) @(negedge clk_in);
            sys_rst_in = 1'b0;
            diff = 1'b0;
            for (int i = 0; i < 60; i++) begin
                @(negedge clk_in);
                if (a == 1 && mlt_a[i] !== mlt) diff = 1'b1;
                mlt_a[i] = mlt;
            end
        end
        chk(8'(diff), 8'h01);
        for (int k = 0; k < 6; k++) begin
            e = 4 + k * 7;
            nj0 = nj;
            nh0 = nh;
            tk0 = ntk;
            go <= 1'b1;
            @(negedge clk_in);
            go <= 1'b0;
            @(negedge clk_in);
            for (int t = 0; t < 2000 && busy; t++) @(negedge clk_in);
            chk(8'(busy), 8'h00);
            repeat (20) @(negedge clk_in);
            chk(8'(ntk - tk0), 8'(e));
            chk(8'(nj - nj0), 8'h01);
            chk(8'(nh - nh0), 8'(e[0]));
        end
        for (int i = 0; i < 30; i++) begin
            ce_in = 1'($random(seed));
            chk(8'(rclk), 8'(ph[psel]));
            @(negedge clk_in);
        end
        ce_in = 1'b1;
        chk(8'(nbad), 8'h00);
        report_and_stop;
    end
endmodule // test_fesc_top
